// ---- hw/amcr_mode_regs.sv ----
// Operation
// - Rate field in bits 7:3 picks sixteen rates from 2.5 to 25600 SPS, reset code 00100.
// - Any rate code from 10000 to 11111 selects the top 40000 SPS rate.
// - Filter field in bits 2:0 picks sinc1..sinc4 or FIR (reset), codes 101-111 reserved.
// - Chop field bits 6:5 of the conversion register: 00 normal (reset), 01 chop.
// - Chop codes 10 and 11 pick two- and four-wire AC excitation, ten-channel part only.
// - Bit 4 of the conversion register picks continuous (0, reset) or one-shot (1).
// - Delay field bits 3:0 inserts a start wait from 50 us (reset) to 17.8 ms; 1110-1111 reserved.
// - Aux register bits 7:4 connect aux pins to analog inputs five to two, off at reset.
// - Aux register bits 3:0 set pin directions, 0 output (reset), 1 input.
// - Pin connect and direction controls exist only on the ten-channel variant.
// - The conversion register sits at index 03h and resets to 01h.
// - The aux pin register sits at index 04h and resets to 00h.
// - The rate and filter register sits at index 02h and resets to 24h.
`timescale 1ns/1ps
`default_nettype none
`include "amcr_defines.svh"

module amcr_mode_regs
    import amcr_pkg::*;
#(
    parameter bit TEN_CHANNEL = 1'b1
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Sequencer interface
    input  wire logic        conv_start,
    output logic             conv_go,
    output logic             delay_busy,
    // Decoded settings
    output amcr_cfg_s        cfg
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    amcr_rate_filt_s rate_filt_q;
    amcr_conv_s      conv_q;
    amcr_aux_s       aux_q;
    logic [31:0]     prdata_q;
    logic            pslverr_q;

    logic [9:0] word_idx;
    logic       sel_rf;
    logic       sel_cv;
    logic       sel_ax;
    logic       mapped;
    logic       wr_en;
    logic       access;

    // Byte address is four times the index; low two address bits ignored
    assign word_idx = paddr[11:2];
    assign sel_rf   = (word_idx == 10'(`AMCR_IDX_RATE_FILT));
    assign sel_cv   = (word_idx == 10'(`AMCR_IDX_CONV));
    assign sel_ax   = (word_idx == 10'(`AMCR_IDX_AUX)) && TEN_CHANNEL;
    assign mapped   = sel_rf || sel_cv || sel_ax;
    assign access   = psel && penable;
    // Only lane 0 carries the byte; writes with lane 0 off change nothing
    assign wr_en    = access && pwrite && pstrb[0];

    // Zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Rate and filter register; reserved codes stored as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_filt_q <= amcr_rate_filt_s'(`AMCR_RST_RATE_FILT);
        end else if (wr_en && sel_rf) begin
            rate_filt_q <= amcr_rate_filt_s'(pwdata[7:0]);
        end
    end

    // Conversion register; bit 7 kept as a plain bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_q <= amcr_conv_s'(`AMCR_RST_CONV);
        end else if (wr_en && sel_cv) begin
            conv_q <= amcr_conv_s'(pwdata[7:0]);
        end
    end

    // Aux pin register; held at reset on the five-channel part
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_q <= amcr_aux_s'(`AMCR_RST_AUX);
        end else if (wr_en && sel_ax) begin
            aux_q <= amcr_aux_s'(pwdata[7:0]);
        end
    end

    // ----------------------------------------------------------------
    // Read path and error answer
    // ----------------------------------------------------------------
    // Read data registered at the end of the setup phase and held through the access phase; unmapped reads return zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
            if (psel && !penable) begin
                pslverr_q <= !mapped;
                if (sel_rf) begin
                    prdata_q <= {24'h0, rate_filt_q};
                end else if (sel_cv) begin
                    prdata_q <= {24'h0, conv_q};
                end else if (sel_ax) begin
                    prdata_q <= {24'h0, aux_q};
                end
            end else if (access) begin
                prdata_q  <= prdata_q;
                pslverr_q <= pslverr_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    logic       ac_ok;
    logic [3:0] pin_conn;
    logic [3:0] pin_oe;
    assign ac_ok = TEN_CHANNEL;

    // The rate code passes through; the fast flag folds codes 10000-11111
    always_comb begin
        cfg.rate_code   = rate_filt_q.output_rate_select;
        cfg.rate_max    = rate_filt_q.output_rate_select >= `AMCR_RATE_FAST_MIN;
        cfg.filter_bad  = rate_filt_q.filter_select > `AMCR_FILT_MAX;
        // Reserved filter codes fall back to FIR so the filter never sees them
        cfg.filter      = cfg.filter_bad ? AMCR_FIR :
                          amcr_filter_e'(rate_filt_q.filter_select);
        // AC excitation degrades to chop where the drive pins do not exist
        if (conv_q.chop_select[1] && !ac_ok) begin
            cfg.chop = AMCR_CHOP;
        end else begin
            cfg.chop = amcr_chop_e'(conv_q.chop_select);
        end
        cfg.single_shot = conv_q.single_or_continuous_select;
        cfg.delay_code  = conv_q.start_delay;
        // Zero delay at the two fastest rates, or a reserved code, is flagged
        cfg.delay_bad   = (conv_q.start_delay > `AMCR_DELAY_MAX) ||
                          ((conv_q.start_delay == `AMCR_DELAY_NONE) &&
                           (cfg.rate_max ||
                            rate_filt_q.output_rate_select == `AMCR_RATE_25600));
        // Pin fields come from the per-pin loop so the struct has one writer
        cfg.pin_connect   = pin_conn;
        cfg.pin_output_en = pin_oe;
    end

    // Per pin: connect bit 7..4 maps to pin 3..0, direction 0 drives
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            assign pin_conn[g] = TEN_CHANNEL && aux_q.aux_pin_connect[g];
            assign pin_oe[g]   = TEN_CHANNEL && !aux_q.aux_pin_input[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Conversion start delay
    // ----------------------------------------------------------------
    logic dly_done;

    amcr_delay_timer u_delay (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (conv_start),
        .delay_code (conv_q.start_delay),
        .busy       (delay_busy),
        .done       (dly_done)
    );

    assign conv_go = dly_done;

    // Wait counter for the shortest code; keeps the bound out of a long delay range
    logic        code1_run_q;
    logic [10:0] code1_wait_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code1_run_q  <= 1'b0;
            code1_wait_q <= 11'h0;
        end else if (conv_start) begin
            code1_run_q  <= (conv_q.start_delay == 4'h1);
            code1_wait_q <= 11'h0;
        end else if (code1_run_q) begin
            if (conv_go) begin
                code1_run_q <= 1'b0;
            end
            // Saturates so a hung timer keeps the check firing
            if (code1_wait_q != 11'h7ff) begin
                code1_wait_q <= code1_wait_q + 11'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_rate_fold: assert property (@(posedge pclk) disable iff (!presetn)
        (rate_filt_q.output_rate_select[4] |-> cfg.rate_max))
        else $error("fast rate code not folded to top rate");

    a_rate_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_rf) |=> (rate_filt_q.output_rate_select == $past(pwdata[7:3])))
        else $error("rate field did not take written value");

    a_filter_fallback: assert property (@(posedge pclk) disable iff (!presetn)
        (rate_filt_q.filter_select > 3'h4) |-> (cfg.filter == AMCR_FIR && cfg.filter_bad))
        else $error("reserved filter code not handled");

    a_chop_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (!conv_q.chop_select[1]) |-> (cfg.chop == amcr_chop_e'(conv_q.chop_select)))
        else $error("chop code not passed through");

    a_ac_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_q.chop_select[1] && TEN_CHANNEL) |-> (cfg.chop[1] == 1'b1))
        else $error("ac excitation not selected");

    a_single_shot: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_cv) |=> (cfg.single_shot == $past(pwdata[4])))
        else $error("conversion mode did not follow write");

    a_delay_done: assert property (@(posedge pclk) disable iff (!presetn)
        (code1_run_q |-> (code1_wait_q <= 11'h4ec)))
        else $error("start delay did not finish in time");

    a_delay_early: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_start && conv_q.start_delay == 4'h1 && !$past(conv_start))
        |=> (!conv_go) [*8])
        else $error("start delay ended too early");

    a_pin_connect: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_ax) |=> (cfg.pin_connect == $past(pwdata[7:4])))
        else $error("pin connect did not follow write");

    a_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_ax) |=> (cfg.pin_output_en == ~$past(pwdata[3:0])))
        else $error("pin direction did not follow write");

    a_conv_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_cv) |=> (prdata[7:0] == conv_q))
        else $error("conversion register readback wrong");

    a_reserved_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && sel_cv) |=> (conv_q.reserved == $past(pwdata[7])))
        else $error("reserved bit not stored");

endmodule
`default_nettype wire

// ---- hw/amcr_defines.svh ----
`ifndef AMCR_DEFINES_SVH
`define AMCR_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (printed offsets are register indices)
// ----------------------------------------------------------------
`define AMCR_IDX_RATE_FILT    8'h02
`define AMCR_IDX_CONV         8'h03
`define AMCR_IDX_AUX          8'h04
`define AMCR_RST_RATE_FILT    8'h24
`define AMCR_RST_CONV         8'h01
`define AMCR_RST_AUX          8'h00

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define AMCR_RATE_FAST_MIN    5'h10
`define AMCR_RATE_25600       5'h0f
`define AMCR_FILT_MAX         3'h4
`define AMCR_DELAY_MAX        4'hd
`define AMCR_DELAY_NONE       4'h0

// ----------------------------------------------------------------
// Start delay timing
// ----------------------------------------------------------------
`define AMCR_PCLK_HZ          25000000
`define AMCR_DELAY_REF_HZ     7372800
// Delay time in ns for a code, rounded up to whole pclk cycles below
`define AMCR_DLY_NS(c) ((c)==1 ? 50000 : (c)==2 ? 59000 : (c)==3 ? 67000 : \
    (c)==4 ? 85000 : (c)==5 ? 119000 : (c)==6 ? 189000 : (c)==7 ? 328000 : \
    (c)==8 ? 605000 : (c)==9 ? 1160000 : (c)==10 ? 2270000 : \
    (c)==11 ? 4490000 : (c)==12 ? 8930000 : (c)==13 ? 17800000 : 0)
`define AMCR_DLY_CYC(c) ((`AMCR_DLY_NS(c) * 64'd25 + 64'd999) / 64'd1000)

`endif

// ---- hw/amcr_pkg.sv ----
`default_nettype none

package amcr_pkg;
    typedef enum logic [2:0] {
        AMCR_SINC1 = 3'h0,
        AMCR_SINC2 = 3'h1,
        AMCR_SINC3 = 3'h2,
        AMCR_SINC4 = 3'h3,
        AMCR_FIR   = 3'h4
    } amcr_filter_e;

    typedef enum logic [1:0] {
        AMCR_NORMAL  = 2'h0,
        AMCR_CHOP    = 2'h1,
        AMCR_AC_TWO  = 2'h2,
        AMCR_AC_FOUR = 2'h3
    } amcr_chop_e;

    typedef struct packed {
        logic [4:0] output_rate_select;
        logic [2:0] filter_select;
    } amcr_rate_filt_s;

    typedef struct packed {
        logic       reserved;
        logic [1:0] chop_select;
        logic       single_or_continuous_select;
        logic [3:0] start_delay;
    } amcr_conv_s;

    typedef struct packed {
        logic [3:0] aux_pin_connect;
        logic [3:0] aux_pin_input;
    } amcr_aux_s;

    // Decoded settings handed to the sequencer, filter and pin mux
    typedef struct packed {
        logic [4:0]   rate_code;
        logic         rate_max;
        amcr_filter_e filter;
        logic         filter_bad;
        amcr_chop_e   chop;
        logic         single_shot;
        logic [3:0]   delay_code;
        logic         delay_bad;
        logic [3:0]   pin_connect;
        logic [3:0]   pin_output_en;
    } amcr_cfg_s;
endpackage

`default_nettype wire

// ---- hw/amcr_delay_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "amcr_defines.svh"

module amcr_delay_timer
    import amcr_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       start,
    input  wire logic [3:0] delay_code,
    // Status
    output logic            busy,
    output logic            done
);

    // ----------------------------------------------------------------
    // Cycle table
    // ----------------------------------------------------------------
    logic [19:0] load_val;
    logic [19:0] cnt_q;
    logic        busy_q;
    logic        done_q;

    // Table is a constant function of the code; reserved codes act as the longest
    always_comb begin
        unique case (delay_code)
            4'h0:    load_val = 20'h0;
            4'h1:    load_val = 20'(`AMCR_DLY_CYC(1));
            4'h2:    load_val = 20'(`AMCR_DLY_CYC(2));
            4'h3:    load_val = 20'(`AMCR_DLY_CYC(3));
            4'h4:    load_val = 20'(`AMCR_DLY_CYC(4));
            4'h5:    load_val = 20'(`AMCR_DLY_CYC(5));
            4'h6:    load_val = 20'(`AMCR_DLY_CYC(6));
            4'h7:    load_val = 20'(`AMCR_DLY_CYC(7));
            4'h8:    load_val = 20'(`AMCR_DLY_CYC(8));
            4'h9:    load_val = 20'(`AMCR_DLY_CYC(9));
            4'ha:    load_val = 20'(`AMCR_DLY_CYC(10));
            4'hb:    load_val = 20'(`AMCR_DLY_CYC(11));
            4'hc:    load_val = 20'(`AMCR_DLY_CYC(12));
            default: load_val = 20'(`AMCR_DLY_CYC(13));
        endcase
    end

    // Down counter; a zero code finishes on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 20'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q  <= load_val;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q <= 20'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    cnt_q  <= 20'h0;
                end else begin
                    cnt_q <= cnt_q - 20'h1;
                end
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;

endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    import amcr_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, conv_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, conv_go, delay_busy;
    amcr_cfg_s   cfg;
    int          n_errors     = 0;
    int          total_checks = 0;
    logic [7:0]  sh_rf, sh_cv, sh_ax;
    logic [31:0] rd;
    logic        er;

    amcr_mode_regs #(.TEN_CHANNEL(1'b1)) u_amcr_mode_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .conv_start(conv_start), .conv_go(conv_go),
        .delay_busy(delay_busy), .cfg(cfg)
    );

    // Free-running 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Expected decoded settings, from the shadow copies of the registers
    function automatic amcr_cfg_s exp_cfg();
        amcr_cfg_s c;
        c.rate_code     = sh_rf[7:3];
        c.rate_max      = sh_rf[7];
        c.filter        = (sh_rf[2:0] > 3'h4) ? AMCR_FIR : amcr_filter_e'(sh_rf[2:0]);
        c.filter_bad    = sh_rf[2:0] > 3'h4;
        c.chop          = amcr_chop_e'(sh_cv[6:5]);
        c.single_shot   = sh_cv[4];
        c.delay_code    = sh_cv[3:0];
        c.delay_bad     = (sh_cv[3:0] > 4'hd) || (sh_cv[3:0] == 4'h0 && sh_rf[7:3] >= 5'h0f);
        c.pin_connect   = sh_ax[7:4];
        c.pin_output_en = ~sh_ax[3:0];
        return c;
    endfunction

    // Start wait in pclk cycles, rounded up
    function automatic int dly_cyc(input logic [3:0] code);
        longint ns;
        case (code)
            4'h1: ns = 50000;    4'h2: ns = 59000;    4'h3: ns = 67000;
            4'h4: ns = 85000;    4'h5: ns = 119000;   4'h6: ns = 189000;
            4'h7: ns = 328000;   4'h8: ns = 605000;   4'h9: ns = 1160000;
            4'ha: ns = 2270000;  4'hb: ns = 4490000;  4'hc: ns = 8930000;
            4'hd: ns = 17800000; default: ns = 0;
        endcase
        return int'((ns * 25 + 999) / 1000);
    endfunction

    // ------------------------------------------------------------
    // APB master: psel stays up so transfers run back to back
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       input logic [3:0] st, output logic [31:0] r, output logic e);
        int          n;
        logic [23:0] hi;
        hi = 24'($urandom);
        // penable is already low here: idle or lowered by the previous transfer
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {hi, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Sample pready and the answer at the rising edge that completes the access
        forever begin
            @(posedge pclk);
            if (pready === 1'b1 || n > 20) break;
            n++;
        end
        r = prdata;
        e = pslverr;
        if (n > 20) chk("pready", 32'h1, 32'(pready));
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [9:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v, 4'($urandom) | 4'h1, rd, er);
        chk("write error flag", 32'h0, 32'(er));
        case (idx)
            10'h2: sh_rf = v;
            10'h3: sh_cv = v;
            10'h4: sh_ax = v;
            default: ;
        endcase
    endtask

    // Read all three back, then the decoded settings with the bus idle
    task automatic check_all;
        apb(1'b0, 10'h2, 8'h00, 4'h0, rd, er);
        chk("rate_and_filter_setup", {24'h0, sh_rf}, rd);
        apb(1'b0, 10'h3, 8'h00, 4'h0, rd, er);
        chk("conversion_setup", {24'h0, sh_cv}, rd);
        apb(1'b0, 10'h4, 8'h00, 4'h0, rd, er);
        chk("aux_pin_setup", {24'h0, sh_ax}, rd);
        psel <= 1'b0;
        @(negedge pclk);
        chk("cfg", 32'(exp_cfg()), 32'(cfg));
        @(posedge pclk);
    endtask

    // Start a conversion (optionally restarted) and time the start wait
    task automatic run_delay(input logic [3:0] code, input bit restart);
        int k, exp;
        wr_reg(10'h3, {sh_cv[7:4], code});
        psel <= 1'b0;
        exp = (dly_cyc(code) == 0) ? 1 : dly_cyc(code);
        @(posedge pclk);
        conv_start <= 1'b1;
        @(posedge pclk);
        conv_start <= 1'b0;
        if (restart) begin
            repeat (100) @(posedge pclk);
            conv_start <= 1'b1;
            @(posedge pclk);
            conv_start <= 1'b0;
        end
        k = 1;
        forever begin
            @(negedge pclk);
            if (conv_go === 1'b1 || k > exp + 10) break;
            if (k == exp / 2) chk("delay_busy mid wait", 32'h1, 32'(delay_busy));
            @(posedge pclk);
            k++;
        end
        chk("start wait in range", 32'h1, 32'(k >= exp && k <= exp + 3));
        @(negedge pclk);
        chk("conv_go single pulse", 32'h0, 32'(conv_go));
        chk("delay_busy after go", 32'h0, 32'(delay_busy));
        @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; conv_start = 1'b0;
        sh_rf = 8'h24; sh_cv = 8'h01; sh_ax = 8'h00;
        void'($urandom(32'h8e5da056));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_all();
        // Corner sweep of every rate, filter, chop and delay boundary
        for (int i = 0; i < 32; i++) begin
            wr_reg(10'h2, {5'(i), 3'(i)});
            wr_reg(10'h3, {i[4], i[1:0], i[3], (i[0] ^ i[4]) ? 4'h0 : 4'(i)});
            wr_reg(10'h4, {4'(i), ~4'(i)});
            check_all();
        end
        // Unmapped places answer with an error, read zero, change nothing
        for (int j = 0; j < 4; j++) begin
            apb(1'b0, (j == 3) ? 10'h3ff : 10'((j == 2) ? 5 : j), 8'h00, 4'h0, rd, er);
            chk("unmapped read data", 32'h0, rd);
            chk("unmapped read error", 32'h1, 32'(er));
            apb(1'b1, (j == 3) ? 10'h3ff : 10'((j == 2) ? 5 : j), 8'h5a, 4'hf, rd, er);
            chk("unmapped write error", 32'h1, 32'(er));
        end
        apb(1'b1, 10'h2, ~sh_rf, 4'he, rd, er); // Byte lane 0 off: ignored
        chk("masked write error", 32'h0, 32'(er));
        check_all();
        // Random traffic, back to back, checked every few transfers
        for (int i = 0; i < 60; i++) begin
            wr_reg(10'(2 + $urandom_range(2)), 8'($urandom));
            if (i % 4 == 3) check_all();
        end
        // Start wait timing: none, shortest, and a restart mid wait
        wr_reg(10'h2, 8'h24);
        run_delay(4'h0, 1'b0);
        run_delay(4'h1, 1'b0);
        run_delay(4'h2, 1'b1);
        // Reset in mid run returns every field to its reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sh_rf = 8'h24; sh_cv = 8'h01; sh_ax = 8'h00;
        @(posedge pclk);
        check_all();
        summarize();
    end

    // Watchdog well beyond the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        summarize();
    end
endmodule

`default_nettype wire
